/* flash_bus_if.sv */
// Peripheral bus connection between the CPU side and the flash interface.
`timescale 1ns/1ps
`default_nettype none
interface flash_bus_if;
  logic        req;
  logic [1:0]  kind;
  logic        regSpace;
  logic [19:0] addr;
  logic [15:0] wdata;
  logic [1:0]  byteEn;
  logic        ack;
  logic [15:0] rdata;
  logic        lowRomRemap;
  logic        bootMode;
  logic        flashRegsEn;
  logic        powerDown;
  logic        supplyLow;
  modport dev  (input req, kind, regSpace, addr, wdata, byteEn, lowRomRemap, bootMode,
                flashRegsEn, powerDown, supplyLow, output ack, rdata);
  modport host (output req, kind, regSpace, addr, wdata, byteEn, lowRomRemap, bootMode,
                flashRegsEn, powerDown, supplyLow, input ack, rdata);
endinterface
`default_nettype wire

/* flash_host.sv */
// CPU-side end: APB command registers driving the peripheral bus.
`timescale 1ns/1ps
`default_nettype none
module flash_host
  import flash_if_pkg::*;
(
  // System.
  input  wire logic        clk,
  input  wire logic        rst_b,
  // APB slave.
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // System controls.
  input  wire logic        bootMode,
  input  wire logic        lowRomRemap,
  input  wire logic        flashRegsEn,
  input  wire logic        supplyLow,
  // Peripheral bus.
  flash_bus_if.host        bus
);
  import flash_if_pkg::*;

  typedef struct packed {
    logic [3:0]  cmd;
    logic [19:0] addr;
    logic [15:0] wdata;
    logic [15:0] rd;
    logic        pending;
    logic        done;
    logic        bootPrev;
    logic        remap;
    logic        power_down_instruction;
    logic [31:0] prdata;
    logic        pready;
  } state_t;

  state_t s_r;
  state_t s_nxt;
  logic   acc;

  always_comb
  begin
    s_nxt = s_r;
    s_nxt.pready = 1'b0;
    s_nxt.power_down_instruction  = 1'b0;
    s_nxt.bootPrev = bootMode;
    acc = psel && penable && !s_r.pready;
    // Bootstrap entry defaults the remap bit to zero.
    if (bootMode && !s_r.bootPrev)
      s_nxt.remap = 1'b0;
    else
      s_nxt.remap = lowRomRemap;
    if (s_r.pending && bus.ack)
    begin
      s_nxt.pending = 1'b0;
      s_nxt.done    = 1'b1;
      s_nxt.rd      = bus.rdata;
    end
    if (acc)
    begin
      s_nxt.pready = 1'b1;
      if (pwrite)
      begin
        unique case (paddr)
          HOFF_CMD:
          begin
            s_nxt.cmd = pwdata[3:0];
            if (pwdata[CMD_POWER_DOWN_INSTRUCTION] && !(bus.ack && s_r.pending))
              s_nxt.power_down_instruction = 1'b1; // software must not do this while writing
            else if (pwdata[CMD_GO] && !s_r.pending)
            begin
              s_nxt.pending = 1'b1;
              s_nxt.done    = 1'b0;
            end
          end
          HOFF_ADDR:  s_nxt.addr  = pwdata[19:0];
          HOFF_WDATA: s_nxt.wdata = pwdata[15:0];
          default: ;
        endcase
      end
      else
      begin
        unique case (paddr)
          HOFF_CMD:    s_nxt.prdata = {28'h0000000, s_r.cmd};
          HOFF_ADDR:   s_nxt.prdata = {12'h000, s_r.addr};
          HOFF_WDATA:  s_nxt.prdata = {16'h0000, s_r.wdata};
          HOFF_STATUS: s_nxt.prdata = {30'h00000000, s_r.done, s_r.pending};
          HOFF_RDATA:  s_nxt.prdata = {16'h0000, s_r.rd};
          default:     s_nxt.prdata = APB_ZERO;
        endcase
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_b)
      s_r <= '0;
    else
      s_r <= s_nxt;
  end

  // Register space versus array space is chosen by address; writes use segment one.
  assign bus.req         = s_r.pending;
  assign bus.kind        = s_r.cmd[CMD_WRITE] ? ACC_DATA_WR : ACC_DATA_RD;
  assign bus.regSpace    = s_r.addr >= ADDR_CTRL0_LO;
  assign bus.addr        = s_r.addr;
  assign bus.wdata       = s_r.wdata;
  assign bus.byteEn      = s_r.cmd[CMD_BYTE] ? {s_r.addr[0], !s_r.addr[0]} : 2'b11;
  assign bus.lowRomRemap = s_r.remap;
  assign bus.bootMode    = bootMode;
  assign bus.flashRegsEn = flashRegsEn;
  assign bus.powerDown   = s_r.power_down_instruction;
  assign bus.supplyLow   = supplyLow;
  assign prdata          = s_r.prdata;
  assign pready          = s_r.pready;
  assign pslverr         = 1'b0;
endmodule
`default_nettype wire

/* flash_if_checker.sv */
// Concurrent checks on the bus between the host end and the flash end.
`timescale 1ns/1ps
`default_nettype none
module flash_if_checker (
  // System.
  input wire logic        clk,
  input wire logic        rst_b,
  // Peripheral bus.
  input wire logic        req,
  input wire logic [1:0]  kind,
  input wire logic        regSpace,
  input wire logic [19:0] addr,
  input wire logic [15:0] wdata,
  input wire logic [1:0]  byteEn,
  input wire logic        ack,
  input wire logic [15:0] rdata,
  input wire logic        flashRegsEn,
  input wire logic        powerDown,
  input wire logic        supplyLow,
  // Device status.
  input wire logic        busy,
  input wire logic        flashOff
);
  import flash_if_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  a_ack_follows_req: assert property (req && !ack && !flashOff |=> ack)
    else $error("request not answered one cycle later");
  a_no_ack_off: assert property (flashOff |=> !ack)
    else $error("answer given while powered down");
  a_pd_switch_off: assert property (powerDown && !busy |=> flashOff)
    else $error("power-down did not switch the module off");
  a_recover_span: assert property ($rose(flashOff) |-> flashOff[*3] ##[1:6] !flashOff)
    else $error("recovery interval wrong");
  // Request fields are held until the answer, so they still qualify rdata here.
  a_trap_busy: assert property (ack && busy && $past(busy) && !regSpace && kind != ACC_DATA_WR
    |-> rdata == TRAP_WORD)
    else $error("array read during write not trapped");
  a_locked_read: assert property (ack && busy && $past(busy) && regSpace && flashRegsEn
    && kind == ACC_DATA_RD && addr >= ADDR_CTRL0_HI && addr <= ADDR_ERR
    |-> rdata == TRAP_WORD)
    else $error("locked register read not trapped");
  a_disabled_zero: assert property (ack && !busy && regSpace && !flashRegsEn
    && $past(!flashRegsEn) && kind == ACC_DATA_RD && addr <= ADDR_ERR
    && addr >= ADDR_CTRL0_LO |-> rdata == ZERO16)
    else $error("disabled register read not zero");
  a_supply_abort: assert property (supplyLow && busy |=> !busy)
    else $error("supply drop did not abort the write");
  a_start_busy: assert property (ack && req && regSpace && kind == ACC_DATA_WR && flashRegsEn
    && addr == ADDR_CTRL0_HI && wdata[BIT_WMS] && byteEn[1] && !supplyLow
    |-> ##[0:1] busy)
    else $error("start bit did not begin a write");
endmodule
`default_nettype wire

/* flash_if_pkg.sv */
// Shared constants and types for the flash write interface and its host.
package flash_if_pkg;
  // Peripheral bus register offsets (byte addresses, low 20 bits).
  localparam logic [19:0] ADDR_CTRL0_LO  = 20'hE0000;
  localparam logic [19:0] ADDR_CTRL0_HI  = 20'hE0002;
  localparam logic [19:0] ADDR_CTRL1_LO  = 20'hE0004;
  localparam logic [19:0] ADDR_CTRL1_HI  = 20'hE0006;
  localparam logic [19:0] ADDR_DATA0_LO  = 20'hE0008;
  localparam logic [19:0] ADDR_DATA0_HI  = 20'hE000A;
  localparam logic [19:0] ADDR_DATA1_LO  = 20'hE000C;
  localparam logic [19:0] ADDR_DATA1_HI  = 20'hE000E;
  localparam logic [19:0] ADDR_PADDR_LO  = 20'hE0010;
  localparam logic [19:0] ADDR_PADDR_HI  = 20'hE0012;
  localparam logic [19:0] ADDR_ERR       = 20'hE0014;
  localparam logic [19:0] ADDR_WP_ALIAS  = 20'hEDFB0;
  localparam logic [19:0] ADDR_WP_VOL    = 20'hEDFB4;
  localparam logic [19:0] ADDR_AP_VOL    = 20'hEDFB8;
  localparam logic [19:0] ADDR_AP_NVOL   = 20'hEDFBC;
  localparam logic [19:0] ADDR_BUS_DUMMY = 20'hEE000;
  // Control register zero low fields.
  localparam int BIT_LOCK      = 4;
  localparam int BIT_BUSY0     = 5;
  localparam int BIT_DBUSY1    = 6;
  localparam int BIT_BUSYNVR   = 1;
  // Control register zero high: write mode start bit.
  localparam int BIT_WMS       = 15;
  localparam logic [15:0] TRAP_WORD = 16'h009B;
  localparam logic [15:0] ZERO16    = 16'h0000;
  // Flash maps.
  localparam logic [19:0] TEST_SECTOR_TOP = 20'h00FFF;
  localparam logic [19:0] SEG1_BASE       = 20'h10000;
  localparam logic [19:0] SECTOR0_TOP     = 20'h11FFF;
  localparam logic [19:0] FLASH_WR_TOP    = 20'h8FFFF;
  localparam logic [19:0] LOW_MAP_SIZE    = 20'h08000;
  localparam logic [19:0] ALIAS_WIN_LO    = 20'h70000;
  localparam logic [19:0] ALIAS_WIN_HI    = 20'h8FFFF;
  localparam logic [3:0]  SECT_TEN        = 4'hA;
  localparam logic [3:0]  SECT_ELEVEN     = 4'hB;
  // Host command register offsets on APB.
  localparam logic [7:0] HOFF_CMD    = 8'h00;
  localparam logic [7:0] HOFF_ADDR   = 8'h04;
  localparam logic [7:0] HOFF_WDATA  = 8'h08;
  localparam logic [7:0] HOFF_STATUS = 8'h0C;
  localparam logic [7:0] HOFF_RDATA  = 8'h10;
  localparam logic [31:0] APB_ZERO   = 32'h0000_0000;
  // Command register fields.
  localparam int CMD_GO     = 0;
  localparam int CMD_WRITE  = 1;
  localparam int CMD_BYTE   = 2;
  localparam int CMD_POWER_DOWN_INSTRUCTION  = 3;
  // Power-down recovery interval.
  localparam int  CLK_MHZ       = 50;
  localparam int  RECOVER_US    = 10;
  localparam int  RECOVER_CYC   = RECOVER_US * CLK_MHZ;
  // Program operation duration (cycles, arbitrary model).
  localparam int  PROG_CYC      = 64;
  // Device access kinds.
  typedef enum logic [1:0] {
    ACC_DATA_RD = 2'b00,
    ACC_DATA_WR = 2'b01,
    ACC_FETCH   = 2'b10
  } acc_t;
endpackage

/* flash_write_interface.sv */
// Flash register interface, sector maps and write sequencing (device end).
// Operation
// - Write map: test sector, sector zero segment one
// - Sectors ten, eleven alias as bank one
// - Remap bit set selects write map reads
// - Bootstrap: test sector fetchable at zero
// - Bootstrap: user flash data access only
// - Host writes flash from segment one base
// - Bootstrap reads follow remap bit
// - Bootstrap entry clears remap bit
// - Registers occupy window through error register
// - Four control, seven address/data/error registers
// - Byte and word register accesses accepted
// - Registers need flash enable bit
// - Protection mirror equals volatile protection
// - Dummy bus register stores, no effect
// - Power-down switches off, recovery needed
// - Host avoids power-down during write
// - Array reads return trap while writing
// - Host runs sequence outside flash
// - Host avoids register writes when locked
// - Supply drop aborts to read mode
// - Start sets lock; locked reads invalid
`timescale 1ns/1ps
`default_nettype none
module flash_write_interface
  import flash_if_pkg::*;
#(
  parameter int RECOVER_CYCLES = flash_if_pkg::RECOVER_CYC,
  parameter int ARRAY_WORDS    = 256
)(
  // System.
  input  wire logic clk,
  input  wire logic rst_b,
  // Peripheral bus.
  flash_bus_if.dev  bus,
  // Status.
  output logic      busy,
  output logic      flashOff
);
  import flash_if_pkg::*;

  localparam int AW = $clog2(ARRAY_WORDS);

  typedef struct packed {
    logic [15:0] ctrl0Lo;
    logic [15:0] ctrl0Hi;
    logic [15:0] ctrl1Lo;
    logic [15:0] ctrl1Hi;
    logic [63:0] data;
    logic [31:0] paddr;
    logic [15:0] err;
    logic [31:0] wpVol;
    logic [15:0] apVol;
    logic [31:0] apNvol;
    logic [15:0] dummy;
    logic        bootSeen;
    logic        off;
    logic [15:0] recover;
    logic [7:0]  progCnt;
    logic        ack;
    logic [15:0] rdata;
  } state_t;

  state_t      s_r;
  state_t      s_nxt;
  logic [15:0] mem_r [ARRAY_WORDS];
  logic        memWe;
  logic [AW-1:0] memIdx;

  logic        writing;
  logic        locked;
  logic        isWord;
  logic [19:0] phys;
  logic        inTest;
  logic        inArray;
  logic [15:0] wmask;
  logic [19:0] regAddr;

  // Merge byte lanes into a 16-bit register.
  function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] nw,
                                        input logic [15:0] m);
    merge = (old & ~m) | (nw & m);
  endfunction

  always_comb
  begin
    writing = s_r.ctrl0Lo[BIT_BUSY0];
    locked  = s_r.ctrl0Lo[BIT_LOCK];
    wmask   = {{8{bus.byteEn[1]}}, {8{bus.byteEn[0]}}};
    // A byte access to the odd address still selects its word; the lanes pick the byte.
    regAddr = {bus.addr[19:1], 1'b0};
    // Remap bit set or a write uses the write map; otherwise low 32 KB sit in segment 1.
    phys = bus.addr;
    if (bus.kind != ACC_DATA_WR && !bus.lowRomRemap && bus.addr < LOW_MAP_SIZE)
      phys = bus.addr + SEG1_BASE;
    inTest  = (bus.kind != ACC_DATA_WR) && bus.bootMode && bus.lowRomRemap
              && bus.addr <= TEST_SECTOR_TOP;
    if (bus.kind == ACC_FETCH && bus.bootMode && bus.addr <= TEST_SECTOR_TOP)
      inTest = 1'b1;
    inArray = !inTest && phys >= SEG1_BASE && phys <= FLASH_WR_TOP;
    if (bus.bootMode && bus.kind == ACC_FETCH)
      inArray = 1'b0;
    isWord  = 1'b1;
    memIdx  = phys[AW:1];
    memWe   = 1'b0;

    s_nxt     = s_r;
    s_nxt.ack = 1'b0;
    s_nxt.rdata = ZERO16;
    // Bootstrap entry forces remap low in the system; here bootMode is captured in bootSeen, which nothing reads.
    s_nxt.bootSeen = bus.bootMode;
    if (bus.powerDown)
    begin
      s_nxt.off     = 1'b1;
      s_nxt.recover = RECOVER_CYCLES[15:0];
    end
    else if (s_r.off)
    begin
      if (s_r.recover == ZERO16)
        s_nxt.off = 1'b0;
      else
        s_nxt.recover = s_r.recover - 16'h0001;
    end
    // Program operation timer.
    if (writing)
    begin
      if (s_r.progCnt == 8'h00)
      begin
        memWe = 1'b1;
        memIdx = s_r.paddr[AW:1];
        s_nxt.ctrl0Lo = ZERO16;
        s_nxt.ctrl0Hi[BIT_WMS] = 1'b0;
      end
      else
        s_nxt.progCnt = s_r.progCnt - 8'h01;
    end
    if (bus.supplyLow)
    begin
      memWe = 1'b0;
      s_nxt.ctrl0Lo = ZERO16;
      s_nxt.ctrl0Hi[BIT_WMS] = 1'b0;
    end

    if (bus.req && !s_r.ack && !s_r.off)
    begin
      s_nxt.ack = 1'b1;
      if (bus.regSpace)
      begin
        if (bus.kind == ACC_DATA_WR)
        begin
          // Writes while locked or disabled are dropped.
          if (bus.flashRegsEn && !locked)
          begin
            unique case (regAddr)
              ADDR_CTRL0_LO:  s_nxt.ctrl0Lo = ZERO16;
              ADDR_CTRL0_HI:
              begin
                s_nxt.ctrl0Hi = merge(s_r.ctrl0Hi, bus.wdata, wmask);
                if (bus.wdata[BIT_WMS] && wmask[BIT_WMS] && !bus.supplyLow)
                begin
                  s_nxt.ctrl0Lo[BIT_LOCK]    = 1'b1;
                  s_nxt.ctrl0Lo[BIT_BUSY0]   = 1'b1;
                  s_nxt.ctrl0Lo[BIT_DBUSY1]  = (s_r.paddr[19:16] == SECT_TEN[3:0]-4'h3)
                                              || (s_r.paddr[19:16] == SECT_ELEVEN[3:0]-4'h3);
                  s_nxt.ctrl0Lo[BIT_BUSYNVR] = 1'b0;
                  s_nxt.progCnt = PROG_CYC[7:0];
                end
              end
              ADDR_CTRL1_LO:  s_nxt.ctrl1Lo = merge(s_r.ctrl1Lo, bus.wdata, wmask);
              ADDR_CTRL1_HI:  s_nxt.ctrl1Hi = merge(s_r.ctrl1Hi, bus.wdata, wmask);
              ADDR_DATA0_LO:  s_nxt.data[15:0]  = merge(s_r.data[15:0], bus.wdata, wmask);
              ADDR_DATA0_HI:  s_nxt.data[31:16] = merge(s_r.data[31:16], bus.wdata, wmask);
              ADDR_DATA1_LO:  s_nxt.data[47:32] = merge(s_r.data[47:32], bus.wdata, wmask);
              ADDR_DATA1_HI:  s_nxt.data[63:48] = merge(s_r.data[63:48], bus.wdata, wmask);
              ADDR_PADDR_LO:  s_nxt.paddr[15:0]  = merge(s_r.paddr[15:0], bus.wdata, wmask);
              ADDR_PADDR_HI:  s_nxt.paddr[31:16] = merge(s_r.paddr[31:16], bus.wdata, wmask);
              ADDR_ERR:       s_nxt.err = merge(s_r.err, bus.wdata, wmask);
              ADDR_WP_ALIAS, ADDR_WP_VOL:
                s_nxt.wpVol[15:0] = merge(s_r.wpVol[15:0], bus.wdata, wmask);
              ADDR_WP_ALIAS + 20'h2, ADDR_WP_VOL + 20'h2:
                s_nxt.wpVol[31:16] = merge(s_r.wpVol[31:16], bus.wdata, wmask);
              ADDR_AP_VOL:    s_nxt.apVol = merge(s_r.apVol, bus.wdata, wmask);
              ADDR_AP_NVOL:   s_nxt.apNvol[15:0] = merge(s_r.apNvol[15:0], bus.wdata, wmask);
              ADDR_AP_NVOL + 20'h2:
                s_nxt.apNvol[31:16] = merge(s_r.apNvol[31:16], bus.wdata, wmask);
              ADDR_BUS_DUMMY: s_nxt.dummy = merge(s_r.dummy, bus.wdata, wmask);
              default: ;
            endcase
          end
        end
        else if (!bus.flashRegsEn)
          s_nxt.rdata = ZERO16;
        else if (regAddr == ADDR_CTRL0_LO)
          s_nxt.rdata = s_r.ctrl0Lo; // Lock status stays visible while locked.
        else if (locked)
          s_nxt.rdata = TRAP_WORD;
        else
        begin
          unique case (regAddr)
            ADDR_CTRL0_HI:  s_nxt.rdata = s_r.ctrl0Hi;
            ADDR_CTRL1_LO:  s_nxt.rdata = s_r.ctrl1Lo;
            ADDR_CTRL1_HI:  s_nxt.rdata = s_r.ctrl1Hi;
            ADDR_DATA0_LO:  s_nxt.rdata = s_r.data[15:0];
            ADDR_DATA0_HI:  s_nxt.rdata = s_r.data[31:16];
            ADDR_DATA1_LO:  s_nxt.rdata = s_r.data[47:32];
            ADDR_DATA1_HI:  s_nxt.rdata = s_r.data[63:48];
            ADDR_PADDR_LO:  s_nxt.rdata = s_r.paddr[15:0];
            ADDR_PADDR_HI:  s_nxt.rdata = s_r.paddr[31:16];
            ADDR_ERR:       s_nxt.rdata = s_r.err;
            ADDR_WP_ALIAS, ADDR_WP_VOL:  s_nxt.rdata = s_r.wpVol[15:0];
            ADDR_WP_ALIAS + 20'h2, ADDR_WP_VOL + 20'h2:
              s_nxt.rdata = s_r.wpVol[31:16];
            ADDR_AP_VOL:    s_nxt.rdata = s_r.apVol;
            ADDR_AP_NVOL:   s_nxt.rdata = s_r.apNvol[15:0];
            ADDR_AP_NVOL + 20'h2: s_nxt.rdata = s_r.apNvol[31:16];
            ADDR_BUS_DUMMY: s_nxt.rdata = s_r.dummy;
            default:        s_nxt.rdata = ZERO16;
          endcase
        end
      end
      else if (bus.kind != ACC_DATA_WR)
      begin
        if (writing)
          s_nxt.rdata = TRAP_WORD;
        else if (inArray)
          s_nxt.rdata = mem_r[phys[AW:1]];
        else
          s_nxt.rdata = ZERO16;
      end
    end
    if (!isWord)
      s_nxt.rdata = ZERO16;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_b)
      s_r <= '0;
    else
      s_r <= s_nxt;
    if (memWe)
      mem_r[memIdx] <= s_r.data[15:0];
  end

  assign bus.ack   = s_r.ack;
  assign bus.rdata = s_r.rdata;
  assign busy      = s_r.ctrl0Lo[BIT_BUSY0];
  assign flashOff  = s_r.off;
endmodule
`default_nettype wire

/* tb.sv */
// Self-checking bench joining the host end and the flash end.
`timescale 1ns/1ps
`default_nettype none
module tb;
  import flash_if_pkg::*;
  logic        clk;
  logic        rst_b;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        bootMode;
  logic        lowRomRemap;
  logic        flashRegsEn;
  logic        supplyLow;
  logic        busy;
  logic        flashOff;
  logic        sawOff;
  logic [31:0] rnd;
  logic [31:0] rd;
  logic [15:0] val;
  logic [19:0] loc;
  int          n_fail;
  int          compares;

  flash_bus_if bus ();
  // A short recovery keeps the power-down scenario brief.
  flash_write_interface #(.RECOVER_CYCLES(4), .ARRAY_WORDS(256)) i_flash_write_interface (
    .clk(clk), .rst_b(rst_b), .bus(bus), .busy(busy), .flashOff(flashOff));
  flash_host i_flash_host (.clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(), .bootMode(bootMode), .lowRomRemap(lowRomRemap), .flashRegsEn(flashRegsEn),
    .supplyLow(supplyLow), .bus(bus));
  flash_if_checker i_flash_if_checker (.clk(clk), .rst_b(rst_b), .req(bus.req),
    .kind(bus.kind), .regSpace(bus.regSpace), .addr(bus.addr), .wdata(bus.wdata),
    .byteEn(bus.byteEn), .ack(bus.ack), .rdata(bus.rdata), .flashRegsEn(bus.flashRegsEn),
    .powerDown(bus.powerDown), .supplyLow(bus.supplyLow), .busy(busy), .flashOff(flashOff));

  initial clk = 1'b0;
  always #10 clk = ~clk;
  always @(posedge clk) if (flashOff === 1'b1) sawOff <= 1'b1;

  function automatic logic [31:0] xorshift(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  function automatic logic [15:0] lane_merge(input logic [15:0] o, input logic [7:0] b,
                                             input logic hi);
    return hi ? {b, o[7:0]} : {o[15:8], b};
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wrap_up();
    $display("counts: %0d compares, %0d mismatches", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    r = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // One bus access through the host; reads fetch the answer afterwards.
  task automatic fop(input logic [3:0] cmd, input logic [19:0] a, input logic [15:0] d);
    apb(1'b1, HOFF_ADDR, {12'h000, a}, rd);
    if (cmd[CMD_WRITE])
      apb(1'b1, HOFF_WDATA, {16'h0000, d}, rd);
    apb(1'b1, HOFF_CMD, {28'h0000000, cmd}, rd);
    for (int n = 0; n < 200 && bus.ack !== 1'b1; n++)
      @(posedge clk);
    if (!cmd[CMD_WRITE])
      apb(1'b0, HOFF_RDATA, APB_ZERO, rd);
  endtask

  initial
  begin
    repeat (20000) @(posedge clk);
    n_fail++;
    $display("timeout at %0t", $time);
    wrap_up();
  end

  initial
  begin
    {rst_b, psel, penable, pwrite, bootMode, lowRomRemap, supplyLow, sawOff} = 8'h00;
    {paddr, pwdata, n_fail, compares} = 0;
    flashRegsEn = 1'b1;
    rnd = 32'h0000_785D;
    repeat (20) @(posedge clk);
    rst_b <= 1'b1;
    rnd = xorshift(rnd);
    val = rnd[15:0];
    fop(4'h3, ADDR_BUS_DUMMY, val);
    fop(4'h1, ADDR_BUS_DUMMY, ZERO16);
    check(rd[15:0], val);
    fop(4'h7, ADDR_BUS_DUMMY + 20'h00001, {rnd[23:16], rnd[23:16]});
    fop(4'h1, ADDR_BUS_DUMMY, ZERO16);
    check(rd[15:0], lane_merge(val, rnd[23:16], 1'b1));
    fop(4'h3, ADDR_WP_VOL, rnd[31:16]);
    fop(4'h1, ADDR_WP_ALIAS, ZERO16);
    check(rd[15:0], rnd[31:16]);
    for (int k = 0; k < 4; k++)
    begin
      rnd = xorshift(rnd);
      fop(4'h3, ADDR_AP_VOL, rnd[15:0]);
      fop(4'h1, ADDR_AP_VOL, ZERO16);
      check(rd[15:0], rnd[15:0]);
    end
    fop(4'h3, ADDR_DATA0_LO, val);
    flashRegsEn <= 1'b0;
    fop(4'h1, ADDR_DATA0_LO, ZERO16);
    check(rd[15:0], ZERO16);
    flashRegsEn <= 1'b1;
    fop(4'h1, ADDR_DATA0_LO, ZERO16);
    check(rd[15:0], val);
    apb(1'b0, 8'h20, APB_ZERO, rd);
    check(rd, APB_ZERO);
    $display("test registers done");
    rnd = xorshift(rnd);
    loc = {13'h0000, rnd[5:0], 1'b0};
    val = rnd[31:16];
    fop(4'h3, ADDR_DATA0_LO, val);
    fop(4'h3, ADDR_PADDR_LO, loc[15:0]);
    fop(4'h3, ADDR_PADDR_HI, 16'h0001);
    fop(4'h3, ADDR_CTRL0_HI, 16'h8000);
    // Reads follow at once so that they land inside the program time.
    fop(4'h1, loc, ZERO16);
    check(rd[15:0], TRAP_WORD);
    fop(4'h1, ADDR_CTRL0_LO, ZERO16);
    check({31'h00000000, rd[BIT_LOCK]}, 32'h0000_0001);
    fop(4'h1, ADDR_PADDR_LO, ZERO16);
    check(rd[15:0], TRAP_WORD);
    for (int n = 0; n < 300 && busy !== 1'b0; n++)
      @(posedge clk);
    bootMode <= 1'b1;
    fop(4'h1, loc, ZERO16);
    check(rd[15:0], val);
    bootMode <= 1'b0;
    lowRomRemap <= 1'b1;
    fop(4'h1, SEG1_BASE | loc, ZERO16);
    check(rd[15:0], val);
    $display("test program done");
    fop(4'h3, ADDR_DATA0_LO, ~val);
    fop(4'h3, ADDR_CTRL0_HI, 16'h8000);
    supplyLow <= 1'b1;
    repeat (2) @(posedge clk);
    check({31'h00000000, busy}, 32'h0000_0000);
    supplyLow <= 1'b0;
    fop(4'h1, SEG1_BASE | loc, ZERO16);
    check(rd[15:0], val);
    $display("test supply drop done");
    apb(1'b1, HOFF_CMD, 32'h0000_0008, rd);
    repeat (3) @(posedge clk);
    check({31'h00000000, sawOff}, 32'h0000_0001);
    fop(4'h1, SEG1_BASE | loc, ZERO16);
    check(rd[15:0], val);
    $display("test power down done");
    wrap_up();
  end
endmodule
`default_nettype wire
